//--- design/ccs_pkg.sv
package ccs_pkg;

	// socket geometry
	localparam int ADDR_W = 26;
	localparam int DATA_W = 16;

	// register offsets on the plain port
	localparam logic [3:0] OFS_CTRL    = 4'h0;
	localparam logic [3:0] OFS_ADDR    = 4'h1;
	localparam logic [3:0] OFS_WDATA   = 4'h2;
	localparam logic [3:0] OFS_CMD     = 4'h3;
	localparam logic [3:0] OFS_STATUS  = 4'h4;
	localparam logic [3:0] OFS_RDATA   = 4'h5;

	// control register field positions
	localparam int CTL_IO_MODE  = 5;
	localparam int CTL_ATA      = 0;
	localparam int CTL_DMA      = 1;
	localparam int CTL_WIDE8    = 2;
	localparam int CTL_IFEN     = 3;
	localparam int CTL_RESET    = 4;
	localparam int CTL_DRQ_LO   = 6;
	localparam int CTL_DRQ_HI   = 7;
	localparam logic [7:0] CTRL_RST = 8'h00;

	// command register field positions
	localparam int CMD_WRITE = 0;
	localparam int CMD_IO    = 1;
	localparam int CMD_ATTR  = 2;
	localparam int CMD_DMA   = 3;
	localparam int CMD_ODD   = 4;

	// status register field positions
	localparam int ST_BUSY   = 0;
	localparam int ST_WP     = 1;
	localparam int ST_WIDE   = 2;
	localparam int ST_INPUT_ACK_N = 3;
	localparam int ST_DRQ    = 4;
	localparam int ST_READY  = 5;
	localparam int ST_IRQ    = 6;
	localparam int ST_SEATED = 7;

	// dma request source select
	localparam logic [1:0] DRQ_WP     = 2'h0;
	localparam logic [1:0] DRQ_INPUT_ACK_N = 2'h1;
	localparam logic [1:0] DRQ_BVD2   = 2'h2;

	// strobe timing in ns and derived cycles at 125 MHz
	localparam int CLK_PS       = 8000;
	localparam int SETUP_NS     = 30;
	localparam int STROBE_NS    = 100;
	localparam int SETUP_CYC    = (SETUP_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int STROBE_CYC   = (STROBE_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam logic [3:0] SETUP_CNT  = 4'(SETUP_CYC);
	localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYC);

	// cycle sequencer states, gray along the usual path
	typedef enum logic [1:0] {
		CCS_IDLE   = 2'b00,
		CCS_SETUP  = 2'b01,
		CCS_STROBE = 2'b11,
		CCS_HOLD   = 2'b10
	} ccs_state_t;

endpackage

//--- design/ccs_socket.sv
// Local design decisions: strobed register access and the address map.
`timescale 1ns/10ps
// Behaviour
// - memory mode: space select picks attribute or common memory
// - i/o mode: space select low for every non-dma i/o cycle outside ata mode
// - dma cycles: space select high during i/o strobes
// - ata mode: space select always high
// - drive 26-bit card address bus as tri-state outputs
// - 16-bit bidirectional data; device drives writes, samples reads
// - non-dma memory read asserts memory read strobe low
// - dma write (i/o read): memory read strobe low only while tc high
// - dma read (i/o write): memory read strobe stays high
// - non-dma memory write asserts memory write strobe low
// - dma read (i/o write): memory write strobe low only while tc high
// - dma write (i/o read): memory write strobe stays high
// - i/o read strobe low for each i/o read
// - i/o write strobe low for each i/o write
// - i/o mode: low shared input marks 16-bit capable access
// - dma mode: software picks dma request pin among three
// - memory mode: ready input readable as status bit 5
// - i/o mode: shared ready line low is interrupt request
// - cycle extended while wait low, ends after it goes high
// - 8-bit cards: only low enable, address bit 0 set for odd
// - card reset high-z unless seated and interface enabled
module ccs_socket
	import ccs_pkg::*;
(
	// clock and reset
	input  wire logic                    clock,
	input  wire logic                    rst_b,
	// register port
	input  wire logic [3:0]              reg_addr,
	input  wire logic [7:0]              reg_wdata,
	input  wire logic                    reg_wr,
	input  wire logic                    reg_rd,
	output logic      [7:0]              reg_rdata,
	// host dma terminal count and card seating
	input  wire logic                    host_tc,
	input  wire logic                    card_seated,
	// socket address and select
	output logic      [ccs_pkg::ADDR_W-1:0] card_addr,
	output logic                         card_addr_oe_n,
	output logic                         space_sel_n,
	output logic      [1:0]              card_enable_n,
	// socket data
	input  wire logic [ccs_pkg::DATA_W-1:0] card_data_in,
	output logic      [ccs_pkg::DATA_W-1:0] card_data_out,
	output logic                         card_data_oe_n,
	// socket strobes
	output logic                         mem_read_strobe_n,
	output logic                         mem_write_strobe_n,
	output logic                         io_read_strobe_n,
	output logic                         io_write_strobe_n,
	output logic                         strobe_oe_n,
	// card reset
	output logic                         card_reset,
	output logic                         card_reset_oe_n,
	// card status inputs
	input  wire logic                    wp_io_wide_capable_n,
	input  wire logic                    input_ack_n,
	input  wire logic                    ready_card_interrupt_n,
	input  wire logic                    wait_n,
	input  wire logic                    battery_status2_pin,
	// decoded status
	output logic                         card_interrupt_n,
	output logic                         card_dma_request_n
);
	import ccs_pkg::*;

	// two-stage synchronisers for all card pins and host tc
	localparam int NSYNC = 7;
	logic [NSYNC-1:0] sync1;
	logic [NSYNC-1:0] sync2;
	logic [NSYNC-1:0] raw_in;
	assign raw_in = {card_seated, host_tc, battery_status2_pin, wait_n,
		ready_card_interrupt_n, input_ack_n, wp_io_wide_capable_n};

	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++)
		begin : g_sync
			always_ff @(posedge clock or negedge rst_b)
			begin
				if (!rst_b)
				begin
					sync1[gi] <= 1'b1;
					sync2[gi] <= 1'b1;
				end
				else
				begin
					sync1[gi] <= raw_in[gi];
					sync2[gi] <= sync1[gi];
				end
			end
		end
	endgenerate

	logic s_wp;
	logic s_input_ack_n;
	logic s_rdy;
	logic s_wait;
	logic s_bvd2;
	logic s_tc;
	logic s_seated;
	assign s_wp     = sync2[0];
	assign s_input_ack_n = sync2[1];
	assign s_rdy    = sync2[2];
	assign s_wait   = sync2[3];
	assign s_bvd2   = sync2[4];
	assign s_tc     = sync2[5];
	assign s_seated = sync2[6];

	// software registers
	logic [7:0]        ctrl;
	logic [ADDR_W-1:0] addr_reg;
	logic [DATA_W-1:0] wdata_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic [4:0]        cmd_reg;
	logic              wide_seen;
	logic              start;

	logic io_mode;
	logic ata_mode;
	logic dma_mode;
	assign io_mode  = ctrl[CTL_IO_MODE];
	assign ata_mode = ctrl[CTL_ATA];
	assign dma_mode = ctrl[CTL_DMA];

	ccs_state_t state;
	ccs_state_t next_state;
	logic [3:0] count;

	// a command write starts a cycle; ignored while one is running
	assign start = reg_wr && reg_addr == OFS_CMD && state == CCS_IDLE;

	// control and address registers; address loads 8 bits per write
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ctrl      <= CTRL_RST;
			addr_reg  <= '0;
			wdata_reg <= '0;
			cmd_reg   <= '0;
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				OFS_CTRL:  ctrl <= reg_wdata;
				OFS_ADDR:  addr_reg <= {addr_reg[ADDR_W-9:0], reg_wdata};
				OFS_WDATA: wdata_reg <= {wdata_reg[DATA_W-9:0], reg_wdata};
				OFS_CMD:   if (state == CCS_IDLE) cmd_reg <= reg_wdata[4:0];
				default:   ;
			endcase
		end
	end

	logic c_write;
	logic c_io;
	logic c_dma;
	assign c_write = cmd_reg[CMD_WRITE];
	assign c_io    = cmd_reg[CMD_IO] || cmd_reg[CMD_DMA];
	assign c_dma   = cmd_reg[CMD_DMA] && dma_mode;

	// cycle sequencer: setup, strobe (stretched by wait), hold
	always_comb
	begin
		next_state = state;
		case (state)
			CCS_IDLE:   if (start) next_state = CCS_SETUP;
			CCS_SETUP:  if (count == 4'h0) next_state = CCS_STROBE;
			CCS_STROBE: if (count == 4'h0 && s_wait) next_state = CCS_HOLD;
			CCS_HOLD:   next_state = CCS_IDLE;
			default:    next_state = CCS_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state <= CCS_IDLE;
			count <= 4'h0;
		end
		else
		begin
			state <= next_state;
			if (state == CCS_IDLE && start)
				count <= SETUP_CNT - 4'h1;
			else if (state == CCS_SETUP && count == 4'h0)
				count <= STROBE_CNT - 4'h1;
			else if (count != 4'h0)
				count <= count - 4'h1;
		end
	end

	// strobe decode; exactly one primary strobe per non-dma cycle
	logic strobing;
	assign strobing = state == CCS_STROBE;
	logic active;
	assign active = state != CCS_IDLE;

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			io_read_strobe_n   <= 1'b1;
			io_write_strobe_n  <= 1'b1;
			mem_read_strobe_n  <= 1'b1;
			mem_write_strobe_n <= 1'b1;
		end
		else
		begin
			io_read_strobe_n   <= !(next_state == CCS_STROBE && c_io && !c_write);
			io_write_strobe_n  <= !(next_state == CCS_STROBE && c_io && c_write);
			if (c_dma)
			begin
				// tc flag rides on the memory strobes during dma
				mem_read_strobe_n  <= !(next_state == CCS_STROBE && !c_write && s_tc);
				mem_write_strobe_n <= !(next_state == CCS_STROBE && c_write && s_tc);
			end
			else
			begin
				mem_read_strobe_n  <= !(next_state == CCS_STROBE && !c_io && !c_write);
				mem_write_strobe_n <= !(next_state == CCS_STROBE && !c_io && c_write);
			end
		end
	end

	// address, select, enables and data drive
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			card_addr      <= '0;
			card_addr_oe_n <= 1'b1;
			space_sel_n    <= 1'b1;
			card_enable_n  <= 2'b11;
			card_data_out  <= '0;
			card_data_oe_n <= 1'b1;
			strobe_oe_n    <= 1'b1;
		end
		else
		begin
			card_addr_oe_n <= !ctrl[CTL_IFEN];
			strobe_oe_n    <= !ctrl[CTL_IFEN];
			card_addr      <= addr_reg;
			if (ctrl[CTL_WIDE8] || !(io_mode && c_io))
				card_addr[0] <= cmd_reg[CMD_ODD];
			if (ata_mode)
				space_sel_n <= 1'b1;
			else if (c_dma && c_io)
				space_sel_n <= 1'b1;
			else if (io_mode && c_io)
				space_sel_n <= !active;
			else
				space_sel_n <= !(active && cmd_reg[CMD_ATTR]);
			if (!active)
				card_enable_n <= 2'b11;
			else if (ctrl[CTL_WIDE8])
				card_enable_n <= 2'b10;
			else if (io_mode && c_io && s_wp)
				card_enable_n <= {1'b1, 1'b0};   // 8-bit i/o when not 16-bit capable
			else
				card_enable_n <= 2'b00;
			card_data_out  <= wdata_reg;
			card_data_oe_n <= !(active && c_write);
		end
	end

	// card data passes two flops like every other pin; the strobe is far
	// longer than the lag, so the capture still sees the card's word
	logic [DATA_W-1:0] data_s1;
	logic [DATA_W-1:0] data_s2;
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			data_s1 <= '0;
			data_s2 <= '0;
		end
		else
		begin
			data_s1 <= card_data_in;
			data_s2 <= data_s1;
		end
	end

	// capture read data on the last strobe cycle, plus 16-bit flag
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rdata_reg <= '0;
			wide_seen <= 1'b0;
		end
		else if (strobing && next_state == CCS_HOLD)
		begin
			if (!c_write)
				rdata_reg <= data_s2;
			wide_seen <= io_mode && !s_wp;
		end
	end

	// card reset drive and decoded card status
	logic [1:0] drq_sel;
	assign drq_sel = ctrl[CTL_DRQ_HI:CTL_DRQ_LO];
	logic drq_now;
	always_comb
	begin
		case (drq_sel)
			DRQ_WP:     drq_now = s_wp;
			DRQ_INPUT_ACK_N: drq_now = s_input_ack_n;
			DRQ_BVD2:   drq_now = s_bvd2;
			default:    drq_now = 1'b1;
		endcase
	end

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			card_reset         <= 1'b0;
			card_reset_oe_n    <= 1'b1;
			card_interrupt_n   <= 1'b1;
			card_dma_request_n <= 1'b1;
		end
		else
		begin
			card_reset         <= ctrl[CTL_RESET];
			card_reset_oe_n    <= !(s_seated && ctrl[CTL_IFEN]);
			card_interrupt_n   <= io_mode ? s_rdy : 1'b1;
			card_dma_request_n <= dma_mode ? drq_now : 1'b1;
		end
	end

	// register read, data one cycle after the strobe
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			reg_rdata <= 8'h00;
		else if (reg_rd)
		begin
			case (reg_addr)
				OFS_CTRL:   reg_rdata <= ctrl;
				OFS_ADDR:   reg_rdata <= addr_reg[7:0];
				OFS_WDATA:  reg_rdata <= wdata_reg[7:0];
				OFS_CMD:    reg_rdata <= {3'h0, cmd_reg};
				OFS_STATUS: reg_rdata <= {s_seated, !io_mode ? 1'b0 : !s_rdy,
					!io_mode ? s_rdy : 1'b0,
					!drq_now, !s_input_ack_n, wide_seen,
					!io_mode ? s_wp : 1'b0,
					active};
				OFS_RDATA:  reg_rdata <= rdata_reg[7:0];
				default:    reg_rdata <= 8'h00;
			endcase
		end
		else
			reg_rdata <= 8'h00;
	end

	// guards
	chk_one_strobe: assert property (@(posedge clock) disable iff (!rst_b)
		!c_dma |-> $countones({~mem_read_strobe_n, ~mem_write_strobe_n,
			~io_read_strobe_n, ~io_write_strobe_n}) <= 1)
		else $error("more than one primary strobe");
	chk_ata_select: assert property (@(posedge clock) disable iff (!rst_b)
		$past(ata_mode) |-> space_sel_n)
		else $error("space select active in ata mode");
	chk_dma_read_oe: assert property (@(posedge clock) disable iff (!rst_b)
		!io_write_strobe_n && $past(c_dma) |-> mem_read_strobe_n)
		else $error("memory read strobe during dma read");
	chk_dma_write_we: assert property (@(posedge clock) disable iff (!rst_b)
		!io_read_strobe_n && $past(c_dma) |-> mem_write_strobe_n)
		else $error("memory write strobe during dma write");
	chk_wait_hold: assert property (@(posedge clock) disable iff (!rst_b)
		strobing && !s_wait |=> strobing)
		else $error("cycle ended while wait low");
	chk_reset_float: assert property (@(posedge clock) disable iff (!rst_b)
		!$past(s_seated) |-> card_reset_oe_n)
		else $error("card reset driven with no card");
	chk_strobe_follow: assert property (@(posedge clock) disable iff (!rst_b)
		start && !reg_wdata[CMD_WRITE] && reg_wdata[CMD_IO] && s_wait
		|-> ##[1:6] !io_read_strobe_n)
		else $error("i/o read strobe missing");
	chk_irq_map: assert property (@(posedge clock) disable iff (!rst_b)
		$past(io_mode) && $past(s_rdy) == 1'b0 |-> !card_interrupt_n)
		else $error("interrupt not passed");
endmodule

//--- tb/ccs_card_model.sv
`timescale 1ns/10ps
module ccs_card_model
(
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rst_b,
	// strobes: mem read, mem write, i/o read, i/o write
	input  wire logic [3:0]  strb,
	// bench controls
	input  wire logic [15:0] read_value,
	input  wire logic [7:0]  wait_len,
	input  wire logic        ack_hold_n,
	// card-driven pins
	output logic      [15:0] card_data_in,
	output logic             input_ack_n,
	output logic             wait_n
);
	logic [15:0] last;
	logic [7:0]  wait_cnt;
	logic        rd_on;
	logic        any_on;

	// decode which strobe is live
	assign rd_on = !strb[3] || !strb[1];
	assign any_on = strb != 4'hf;
	// released bus inverts each cycle, so stale data matches the last word only on alternate cycles
	assign card_data_in = rd_on ? read_value : ~last;
	// acknowledge on i/o reads; bench may hold it low for dma request use
	assign input_ack_n = strb[1] && ack_hold_n;
	// wait low for the first wait_len strobe cycles, pulled up otherwise
	assign wait_n = !(any_on && wait_cnt < wait_len);

	// bus pattern and wait counter
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			last <= 16'h0000;
			wait_cnt <= 8'h00;
		end
		else
		begin
			last <= card_data_in;
			wait_cnt <= any_on ? wait_cnt + 8'h01 : 8'h00;
		end
	end
endmodule

//--- tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	import ccs_pkg::*;
	// bench-driven inputs
	logic              clock, rst_b, reg_wr, reg_rd, host_tc, card_seated, ack_hold_n;
	logic              wp_io_wide_capable_n, ready_card_interrupt_n, battery_status2_pin;
	logic [3:0]        reg_addr;
	logic [7:0]        reg_wdata, wait_len, d;
	logic [15:0]       read_value;
	// design and card outputs
	logic [7:0]        reg_rdata;
	logic [ADDR_W-1:0] card_addr, s_addr;
	logic [DATA_W-1:0] card_data_in, card_data_out, s_dout;
	logic [1:0]        card_enable_n, s_en;
	logic              card_addr_oe_n, space_sel_n, card_data_oe_n, strobe_oe_n, card_reset;
	logic              mem_read_strobe_n, mem_write_strobe_n, io_read_strobe_n;
	logic              io_write_strobe_n, card_reset_oe_n, card_interrupt_n;
	logic              card_dma_request_n, input_ack_n, wait_n, sp, s_doe;
	logic [3:0]        sv, strb;
	int                len, bad_count, cmp_count, ticks;

	assign strb = {mem_read_strobe_n, mem_write_strobe_n, io_read_strobe_n, io_write_strobe_n};

	ccs_socket u_ccs_socket (.clock, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .host_tc, .card_seated, .card_addr, .card_addr_oe_n, .space_sel_n,
		.card_enable_n, .card_data_in, .card_data_out, .card_data_oe_n, .mem_read_strobe_n,
		.mem_write_strobe_n, .io_read_strobe_n, .io_write_strobe_n, .strobe_oe_n,
		.card_reset, .card_reset_oe_n, .wp_io_wide_capable_n, .input_ack_n,
		.ready_card_interrupt_n, .wait_n, .battery_status2_pin, .card_interrupt_n,
		.card_dma_request_n);

	ccs_card_model u_ccs_card_model (.clock, .rst_b, .strb, .read_value, .wait_len,
		.ack_hold_n, .card_data_in, .input_ack_n, .wait_n);

	// free-running clock
	initial
	begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	// hang guard, far above the few hundred cycles needed
	always @(posedge clock)
	begin
		ticks++;
		if (ticks == 20000)
		begin
			bad_count++;
			complete_run();
		end
	end

	task automatic complete_run();
		if (bad_count == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// one-cycle strobes with a gap, so no signal is assigned twice per step
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
		@(posedge clock);
	endtask

	task automatic rd(input logic [3:0] a);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		@(posedge clock);
		d = reg_rdata;
	endtask

	task automatic setup(input logic [7:0] ctl, input logic [31:0] a, input logic [15:0] w);
		wr(OFS_CTRL, ctl);
		for (int i = 3; i >= 0; i--)
			wr(OFS_ADDR, a[i*8 +: 8]);
		wr(OFS_WDATA, w[15:8]);
		wr(OFS_WDATA, w[7:0]);
	endtask

	// issue a command, snapshot the first strobe cycle, measure strobe length
	task automatic cyc(input logic [7:0] cmd);
		int n;
		n = 0;
		len = 0;
		sv = 4'hf;
		wr(OFS_CMD, cmd);
		while (n < 300 && (len == 0 || strb != 4'hf))
		begin
			@(posedge clock);
			n++;
			if (strb != 4'hf && len == 0)
			begin
				sv = strb;
				sp = space_sel_n;
				s_en = card_enable_n;
				s_addr = card_addr;
				s_dout = card_data_out;
				s_doe = card_data_oe_n;
			end
			if (strb != 4'hf)
				len++;
		end
		repeat (4) @(posedge clock);
		rd(OFS_STATUS);
		chk("busy", d[ST_BUSY], 1'b0);
	endtask

	task automatic t_reset();
		chk("idle strobes", strb, 4'hf);
		chk("reset oe unseated", card_reset_oe_n, 1'b1);
		card_seated <= 1'b1;
		wr(OFS_CTRL, 8'h18);
		repeat (4) @(posedge clock);
		chk("reset oe seated", card_reset_oe_n, 1'b0);
		chk("card reset", card_reset, 1'b1);
		wr(OFS_CTRL, 8'h10);
		// the enable register follows the control write by one more edge
		@(posedge clock);
		chk("reset oe disabled", card_reset_oe_n, 1'b1);
	endtask

	task automatic t_mem();
		setup(8'h08, 32'h0234_5678, 16'hbeef);
		read_value <= 16'h5aa5;
		cyc(8'h04);
		chk("mem rd strobes", sv, 4'b0111);
		chk("attr space", sp, 1'b0);
		chk("strobe width", len >= STROBE_CYC, 1'b1);
		chk("addr", s_addr, 26'h234_5678);
		chk("addr oe", card_addr_oe_n, 1'b0);
		chk("strobe oe", strobe_oe_n, 1'b0);
		chk("data oe on read", s_doe, 1'b1);
		rd(OFS_RDATA);
		chk("rdata", d, 8'ha5);
		cyc(8'h01);
		chk("mem wr strobes", sv, 4'b1011);
		chk("common space", sp, 1'b1);
		chk("wdata", s_dout, 16'hbeef);
		chk("data oe on write", s_doe, 1'b0);
	endtask

	task automatic t_io();
		wp_io_wide_capable_n <= 1'b0;
		setup(8'h28, 32'h0000_03f8, 16'h1234);
		cyc(8'h02);
		chk("io rd strobes", sv, 4'b1101);
		chk("io rd space", sp, 1'b0);
		chk("io wide enables", s_en, 2'b00);
		rd(OFS_STATUS);
		chk("wide access", d[ST_WIDE], 1'b1);
		cyc(8'h03);
		chk("io wr strobes", sv, 4'b1110);
		chk("io wr space", sp, 1'b0);
		// card now reports an 8-bit location: only the low enable may fall
		wp_io_wide_capable_n <= 1'b1;
		cyc(8'h02);
		chk("io narrow enables", s_en, 2'b10);
		rd(OFS_STATUS);
		chk("narrow access", d[ST_WIDE], 1'b0);
	endtask

	task automatic t_dma();
		host_tc <= 1'b1;
		wr(OFS_CTRL, 8'h2a);
		cyc(8'h0a);
		chk("dma wr tc", sv, 4'b0101);
		chk("dma space", sp, 1'b1);
		cyc(8'h0b);
		chk("dma rd tc", sv, 4'b1010);
		chk("dma space", sp, 1'b1);
		host_tc <= 1'b0;
		cyc(8'h0b);
		chk("dma rd no tc", sv, 4'b1110);
		cyc(8'h0a);
		chk("dma wr no tc", sv, 4'b1101);
	endtask

	task automatic t_ata_wait();
		wr(OFS_CTRL, 8'h09);
		cyc(8'h04);
		chk("ata space", sp, 1'b1);
		wr(OFS_CTRL, 8'h08);
		wait_len <= 8'd40;
		cyc(8'h00);
		chk("wait stretch", len >= 40 && len <= 48, 1'b1);
		wait_len <= 8'd0;
		setup(8'h0c, 32'h0000_0100, 16'h0000);
		cyc(8'h10);
		chk("byte enables", s_en, 2'b10);
		chk("odd addr bit", s_addr[0], 1'b1);
	endtask

	task automatic t_status();
		wr(OFS_CTRL, 8'h08);
		for (int v = 0; v < 2; v++)
		begin
			wp_io_wide_capable_n <= v[0];
			ready_card_interrupt_n <= !v[0];
			repeat (4) @(posedge clock);
			rd(OFS_STATUS);
			chk("wp status", d[ST_WP], v[0]);
			chk("ready status", d[ST_READY], !v[0]);
			chk("no irq in mem mode", card_interrupt_n, 1'b1);
		end
		wr(OFS_CTRL, 8'h28);
		repeat (4) @(posedge clock);
		chk("irq", card_interrupt_n, 1'b0);
	endtask

	task automatic t_drq();
		for (int s = 0; s < 3; s++)
			for (int v = 0; v < 2; v++)
			begin
				wr(OFS_CTRL, 8'h2a | 8'(s << 6));
				wp_io_wide_capable_n <= (s == 0) ? v[0] : !v[0];
				ack_hold_n <= (s == 1) ? v[0] : !v[0];
				battery_status2_pin <= (s == 2) ? v[0] : !v[0];
				repeat (4) @(posedge clock);
				chk("dma request", card_dma_request_n, v[0]);
			end
	endtask

	// reset, then every scenario in turn
	initial
	begin
		rst_b = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		host_tc = 1'b0;
		card_seated = 1'b0;
		ack_hold_n = 1'b1;
		wp_io_wide_capable_n = 1'b1;
		ready_card_interrupt_n = 1'b1;
		battery_status2_pin = 1'b1;
		read_value = 16'h0000;
		wait_len = 8'h00;
		repeat (20) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		t_reset();
		t_mem();
		t_io();
		t_dma();
		t_ata_wait();
		t_status();
		t_drq();
		complete_run();
	end
endmodule
